// ### design/tai_interrupt_pin_config.sv
/*
  transceiver interrupt status, unmask, summary and pin function enables
  behind an avalon-mm slave with waitrequest.
  assumes the fifo and receive strobes are on CORE_CLK; the user pin is
  asynchronous.
*/
// Local design decision: the Avalon-MM interface to the registers.
`include "tai_irq_map.svh"
`default_nettype none

module tai_interrupt_pin_config (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // user pin
  input  wire logic        USER_ONE_PIN,
  // receive stream
  input  wire logic        RX_ACTIVE,
  input  wire logic        RX_BIT_VALID,
  input  wire logic        RX_BIT,
  // asynchronous transmit fifo
  input  wire logic        TX_FIFO_WRITE,
  input  wire logic        TX_FIFO_FULL,
  input  wire logic        TX_FIFO_READ,
  input  wire logic        TX_FIFO_EMPTY,
  // outputs
  output logic [7:0]       PIN_FUNCTION_EN,
  output logic             MORE_INTERRUPTS_SUMMARY
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  tai_irq_pkg::av_req_t    req;
  tai_irq_pkg::bus_state_t bus_state_r;
  logic [5:0]              idx;
  logic                    word_ok;
  logic                    wr_go;
  logic                    rd_take;
  logic                    lane0;
  logic [7:0]              wbyte;
  logic [7:0]              rd_byte;
  logic [31:0]             readdata_r;

  assign req.read       = AVS_READ;
  assign req.write      = AVS_WRITE;
  assign req.address    = AVS_ADDRESS;
  assign req.writedata  = AVS_WRITEDATA;
  assign req.byteenable = AVS_BYTEENABLE;

  assign idx     = req.address[7:2];
  assign word_ok = (req.address[1:0] == 2'h0);
  assign lane0   = req.byteenable[0];
  assign wbyte   = req.writedata[7:0];

  // one wait cycle, then the answer
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_state_r <= tai_irq_pkg::BUS_IDLE;
    end else begin
      case (bus_state_r)
        tai_irq_pkg::BUS_IDLE: begin
          if (req.read || req.write) begin
            bus_state_r <= tai_irq_pkg::BUS_ANSWER;
          end
        end
        tai_irq_pkg::BUS_ANSWER: bus_state_r <= tai_irq_pkg::BUS_IDLE;
        default:                 bus_state_r <= tai_irq_pkg::BUS_IDLE;
      endcase
    end
  end

  assign AVS_WAITREQUEST = (req.read || req.write) && (bus_state_r != tai_irq_pkg::BUS_ANSWER);
  assign wr_go           = req.write && (bus_state_r == tai_irq_pkg::BUS_ANSWER) && word_ok &&
                           lane0;
  assign rd_take         = req.read && (bus_state_r == tai_irq_pkg::BUS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [3:0]              unmask_r;
  logic [7:0]              pin_fn_r;
  tai_irq_pkg::edge_sel_t  edge_sel_r;
  logic                    rl_disable_r;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      unmask_r <= `TAI_UNMASK_RST;
    end else if (wr_go && idx == `TAI_IDX_UNMASK) begin
      unmask_r <= wbyte[3:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_fn_r <= `TAI_PIN_FN_RST;
    end else if (wr_go && idx == `TAI_IDX_PIN_FN) begin
      pin_fn_r <= wbyte;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      edge_sel_r <= tai_irq_pkg::EDGE_OFF;
    end else if (wr_go && idx == `TAI_IDX_EDGE_CFG) begin
      edge_sel_r <= tai_irq_pkg::edge_sel_t'(wbyte[`TAI_EDGE_HI:`TAI_EDGE_LO]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rl_disable_r <= 1'b0;
    end else if (wr_go && idx == `TAI_IDX_RX_CHECK) begin
      rl_disable_r <= wbyte[`TAI_RLDIS_BIT];
    end
  end

  assign PIN_FUNCTION_EN = pin_fn_r;

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  tai_irq_pkg::event_vec_t ev;
  logic                    user_pulse;
  logic                    rl_pulse;

  user_pin_edge_detect u_user_edge (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .pin_async  (USER_ONE_PIN),
    .edge_sel   (edge_sel_r),
    .edge_pulse (user_pulse)
  );

  run_length_checker u_run_length (
    .clk           (CORE_CLK),
    .rst_n         (RESETN),
    .rx_active     (RX_ACTIVE),
    .bit_valid     (RX_BIT_VALID),
    .bit_value     (RX_BIT),
    .check_disable (rl_disable_r),
    .error_pulse   (rl_pulse)
  );

  assign ev.user_pin     = user_pulse;
  assign ev.run_length   = rl_pulse;
  assign ev.tx_overflow  = TX_FIFO_WRITE & TX_FIFO_FULL;
  assign ev.tx_underflow = TX_FIFO_READ & TX_FIFO_EMPTY;

  ////////////////////////////////////////////////////////////////////////////
  // status flags and summary

  logic [3:0] status_r;
  logic [3:0] status_nxt;
  logic [3:0] clr;
  logic       summary_r;

  // the documented register and the clear alias both clear by ones
  always_comb begin
    clr = 4'h0;
    if (wr_go && (idx == `TAI_IDX_STATUS || idx == `TAI_IDX_CLEAR)) begin
      clr = wbyte[3:0];
    end
  end

  // a new event wins over a clear in the same cycle
  assign status_nxt = (status_r & ~clr) | ev;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_r <= `TAI_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= |(status_r & unmask_r);
    end
  end

  assign MORE_INTERRUPTS_SUMMARY = summary_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    rd_byte = 8'h00;
    if (word_ok) begin
      case (idx)
        `TAI_IDX_STATUS:   rd_byte = {4'h0, status_r};
        `TAI_IDX_UNMASK:   rd_byte = {4'h0, unmask_r};
        `TAI_IDX_PIN_FN:   rd_byte = pin_fn_r;
        `TAI_IDX_EDGE_CFG: rd_byte = {3'h0, edge_sel_r, 3'h0};
        `TAI_IDX_RX_CHECK: rd_byte = {7'h00, rl_disable_r};
        `TAI_IDX_SUMMARY:  rd_byte = {7'h00, summary_r};
        default:           rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      readdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign AVS_READDATA = readdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_status_write;
    wr_go && idx == `TAI_IDX_STATUS;
  endsequence

  sequence s_unmasked_flag;
    |(status_r & unmask_r);
  endsequence

  chk_w1c_clear: assert property (
    s_status_write ##0 (wbyte[`TAI_BIT_OVF] && !ev.tx_overflow)
      |=> !status_r[`TAI_BIT_OVF])
    else $error("status write of one did not clear overflow flag");

  chk_zero_keeps: assert property (
    (s_status_write or (wr_go && idx == `TAI_IDX_CLEAR)) ##0 (wbyte[3:0] == 4'h0)
      |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status write of zero changed a flag");

  chk_summary_report: assert property (
    s_unmasked_flag |=> MORE_INTERRUPTS_SUMMARY)
    else $error("unmasked flag not reported in summary");

  chk_reserved_read: assert property (
    (rd_take && (idx == `TAI_IDX_STATUS || idx == `TAI_IDX_UNMASK))
      |=> AVS_READDATA[31:4] == 28'h000_0000)
    else $error("reserved status or unmask bits read non-zero");

  chk_user_set: assert property (
    user_pulse |=> status_r[`TAI_BIT_USER])
    else $error("user pin change did not set flag");

  chk_edge_off: assert property (
    (edge_sel_r == tai_irq_pkg::EDGE_OFF) [*2] |-> !user_pulse)
    else $error("user pin flag raised while detection disabled");

  chk_runlen_set: assert property (
    rl_pulse |=> status_r[`TAI_BIT_RUNLEN])
    else $error("run-length error did not set flag");

  chk_runlen_quiet: assert property (
    $past(rl_disable_r) && rl_disable_r |-> !rl_pulse)
    else $error("run-length error raised while disabled");

  chk_overflow_set: assert property (
    TX_FIFO_WRITE && TX_FIFO_FULL |=> status_r[`TAI_BIT_OVF] ##1 1'b1)
    else $error("write to full fifo did not set overflow");

  chk_underflow_set: assert property (
    TX_FIFO_READ && TX_FIFO_EMPTY |=> status_r[`TAI_BIT_UNF])
    else $error("read of empty fifo did not set underflow");

  chk_mask_gates: assert property (
    (unmask_r == 4'h0) [*2] |-> !MORE_INTERRUPTS_SUMMARY)
    else $error("summary raised with all flags masked");

  chk_pin_write: assert property (
    wr_go && idx == `TAI_IDX_PIN_FN |=> PIN_FUNCTION_EN == $past(wbyte))
    else $error("pin function register did not take written value");

  chk_summary_exact: assert property (
    !(|(status_r & unmask_r)) |=> !MORE_INTERRUPTS_SUMMARY)
    else $error("summary high without an unmasked flag one cycle before");

  chk_alias_clear: assert property (
    (wr_go && idx == `TAI_IDX_CLEAR) ##0 (wbyte[`TAI_BIT_UNF] && !ev.tx_underflow)
      |=> !status_r[`TAI_BIT_UNF])
    else $error("clear register write of one did not clear underflow flag");

  chk_user_clear: assert property (
    s_status_write ##0 (wbyte[`TAI_BIT_USER] && !user_pulse)
      |=> !status_r[`TAI_BIT_USER])
    else $error("status write of one did not clear user pin flag");

  chk_flags_sticky: assert property (
    !(wr_go && (idx == `TAI_IDX_STATUS || idx == `TAI_IDX_CLEAR))
      |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status flag dropped without a clearing write");

  chk_unmask_write: assert property (
    wr_go && idx == `TAI_IDX_UNMASK |=> {4'h0, unmask_r} == ($past(wbyte) & 8'h0F))
    else $error("unmask register did not take written value");

  chk_unmask_hold: assert property (
    !(wr_go && idx == `TAI_IDX_UNMASK) |=> $stable(unmask_r))
    else $error("unmask register changed without a write");

  chk_pin_hold: assert property (
    !(wr_go && idx == `TAI_IDX_PIN_FN) |=> $stable(PIN_FUNCTION_EN))
    else $error("pin function register changed without a write");

  chk_read_stands: assert property (
    AVS_READ && !AVS_WAITREQUEST |=> $stable(AVS_READDATA))
    else $error("read data changed at the answer edge");

  chk_read_upper: assert property (
    AVS_READDATA[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");

  chk_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer took more than one wait cycle");

endmodule // tai_interrupt_pin_config

`default_nettype wire

// ### design/tai_irq_map.svh
/*
  register indices, bit positions, reset values and limits of the
  transceiver interrupt and pin configuration block.
  assumes byte addressing on the bus, one 32-bit word per index.
*/
`ifndef TAI_IRQ_MAP_SVH
`define TAI_IRQ_MAP_SVH

// register indices (byte address = 4 * index)
`define TAI_IDX_SUMMARY      6'h04
`define TAI_IDX_EDGE_CFG     6'h07
`define TAI_IDX_STATUS       6'h0B
`define TAI_IDX_UNMASK       6'h0C
`define TAI_IDX_PIN_FN       6'h0D
`define TAI_IDX_RX_CHECK     6'h1B
`define TAI_IDX_CLEAR        6'h20

// field positions
`define TAI_BIT_USER         3
`define TAI_BIT_RUNLEN       2
`define TAI_BIT_OVF          1
`define TAI_BIT_UNF          0
`define TAI_EDGE_LO          3
`define TAI_EDGE_HI          4
`define TAI_RLDIS_BIT        0

// reset values
`define TAI_STATUS_RST       4'h4
`define TAI_UNMASK_RST       4'h0
`define TAI_PIN_FN_RST       8'hFF
`define TAI_EDGE_RST         2'h0

// run-length limits, two's complement on 7 bits
`define TAI_RL_ONES_LIMIT    7'h19
`define TAI_RL_ZEROS_LIMIT   7'h65

`endif

// ### design/tai_irq_pkg.sv
/*
  types shared by the transceiver interrupt block and its helpers.
  assumes tai_irq_map.svh supplies the register map constants; the enum codes are set here.
*/
`default_nettype none

package tai_irq_pkg;

  // edge-select codes of the user pin detector
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  // bus answer state, gray along idle -> answer
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_ANSWER = 2'h1
  } bus_state_t;

  // one bit per status event, msb first
  typedef struct packed {
    logic user_pin;
    logic run_length;
    logic tx_overflow;
    logic tx_underflow;
  } event_vec_t;

  // avalon request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

endpackage : tai_irq_pkg

`default_nettype wire

// ### design/user_pin_edge_detect.sv
/*
  synchronises the user pin and flags the selected transitions.
  assumes the pin is asynchronous to the clock.
*/
`include "tai_irq_map.svh"
`default_nettype none

module user_pin_edge_detect (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // pin and selection
  input  wire logic                  pin_async,
  input  wire tai_irq_pkg::edge_sel_t edge_sel,
  // detected change
  output logic                       edge_pulse
);

  logic sync_a_r;
  logic sync_b_r;
  logic prev_r;
  logic pulse_r;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      sync_a_r <= pin_async;
      sync_b_r <= sync_a_r;
      prev_r   <= sync_b_r;
    end
  end

  assign rise = sync_b_r & ~prev_r;
  assign fall = ~sync_b_r & prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_r <= 1'b0;
    end else begin
      case (edge_sel)
        tai_irq_pkg::EDGE_RISE: pulse_r <= rise;
        tai_irq_pkg::EDGE_FALL: pulse_r <= fall;
        tai_irq_pkg::EDGE_BOTH: pulse_r <= rise | fall;
        default:                pulse_r <= 1'b0;
      endcase
    end
  end

  assign edge_pulse = pulse_r;

endmodule // user_pin_edge_detect

`default_nettype wire

// ### design/run_length_checker.sv
/*
  tracks ones minus zeros over a received message and flags imbalance.
  assumes bit_valid marks one received bit per cycle, same clock.
*/
`include "tai_irq_map.svh"
`default_nettype none

module run_length_checker (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // receive stream
  input  wire logic rx_active,
  input  wire logic bit_valid,
  input  wire logic bit_value,
  input  wire logic check_disable,
  // imbalance detected
  output logic      error_pulse
);

  logic [6:0] balance_r;
  logic [6:0] balance_nxt;
  logic       at_limit;
  logic       err_r;
  logic       hit;

  assign balance_nxt = bit_value ? 7'(balance_r + 7'h01) : 7'(balance_r - 7'h01);
  assign at_limit    = (balance_r == `TAI_RL_ONES_LIMIT) || (balance_r == `TAI_RL_ZEROS_LIMIT);
  assign hit         = (balance_nxt == `TAI_RL_ONES_LIMIT) ||
                       (balance_nxt == `TAI_RL_ZEROS_LIMIT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      balance_r <= 7'h00;
    end else if (!rx_active || check_disable) begin
      balance_r <= 7'h00;
    end else if (bit_valid && !at_limit) begin
      balance_r <= balance_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else begin
      err_r <= rx_active & ~check_disable & bit_valid & ~at_limit & hit;
    end
  end

  assign error_pulse = err_r;

endmodule // run_length_checker

`default_nettype wire

// ### tb/tb_top.sv
/*
  self-checking bench for the transceiver interrupt and pin configuration block.
  assumes an avalon-mm slave with waitrequest on the one bench clock.
*/
`default_nettype none

`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp); end end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] A_SUM    = 8'h10;
  localparam logic [7:0] A_EDGE   = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h2C;
  localparam logic [7:0] A_UNMASK = 8'h30;
  localparam logic [7:0] A_PIN    = 8'h34;
  localparam logic [7:0] A_RXCHK  = 8'h6C;
  localparam logic [7:0] A_CLR    = 8'h80;
  localparam logic [7:0] A_HOLE   = 8'h44;

  logic        clk;
  logic        resetn;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        user_pin;
  logic        rx_active;
  logic        rx_valid;
  logic        rx_bit;
  logic        fifo_wr;
  logic        fifo_full;
  logic        fifo_rd;
  logic        fifo_empty;
  logic [7:0]  pin_en;
  logic        summary;
  logic [31:0] q;
  logic        exp_flag;
  int          num_errors;
  int          cmp_count;
  int          cyc;

  tai_interrupt_pin_config uut (
    .CORE_CLK                (clk),
    .RESETN                  (resetn),
    .AVS_ADDRESS             (address),
    .AVS_READ                (read),
    .AVS_WRITE               (write),
    .AVS_WRITEDATA           (writedata),
    .AVS_BYTEENABLE          (byteenable),
    .AVS_READDATA            (readdata),
    .AVS_WAITREQUEST         (waitrequest),
    .USER_ONE_PIN            (user_pin),
    .RX_ACTIVE               (rx_active),
    .RX_BIT_VALID            (rx_valid),
    .RX_BIT                  (rx_bit),
    .TX_FIFO_WRITE           (fifo_wr),
    .TX_FIFO_FULL            (fifo_full),
    .TX_FIFO_READ            (fifo_rd),
    .TX_FIFO_EMPTY           (fifo_empty),
    .PIN_FUNCTION_EN         (pin_en),
    .MORE_INTERRUPTS_SUMMARY (summary)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus access
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address    <= a;
    read       <= ~w;
    write      <= w;
    writedata  <= {24'h000000, d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      num_errors++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string msg);
    bus(1'b0, a, 8'h00, 4'hF);
    `CHK(q, {24'h000000, e}, msg)
  endtask

  task automatic sum_chk(input logic e);
    @(posedge clk);
    @(negedge clk);
    `CHK(summary, e, "summary")
  endtask

  task automatic send_bits(input int n, input logic v);
    repeat (n) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_bit   <= v;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse(input logic w, input logic full_or_empty);
    @(posedge clk);
    fifo_wr    <= w;
    fifo_rd    <= ~w;
    fifo_full  <= full_or_empty & w;
    fifo_empty <= full_or_empty & ~w;
    @(posedge clk);
    fifo_wr <= 1'b0;
    fifo_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    num_errors = 0;
    cmp_count  = 0;
    cyc        = 0;
    resetn = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    user_pin = 1'b0;
    rx_active = 1'b0;
    rx_valid = 1'b0;
    rx_bit = 1'b0;
    fifo_wr = 1'b0;
    fifo_full = 1'b0;
    fifo_rd = 1'b0;
    fifo_empty = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;

    // reset values
    rd_chk(A_STATUS, 8'h04, "status reset");
    rd_chk(A_UNMASK, 8'h00, "unmask reset");
    rd_chk(A_PIN, 8'hFF, "pin reset");
    `CHK(pin_en, 8'hFF, "pin port")
    sum_chk(1'b0);
    $display("test reset done");

    // write one to clear, zero keeps, holes
    wr(A_STATUS, 8'h00);
    rd_chk(A_STATUS, 8'h04, "zero keeps");
    wr(A_STATUS, 8'h04);
    rd_chk(A_STATUS, 8'h00, "one clears");
    rd_chk(A_HOLE, 8'h00, "hole read");
    wr(A_HOLE, 8'h00);
    rd_chk(A_PIN, 8'hFF, "hole write");
    $display("test clear done");

    // fifo events and summary
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b0);
    rd_chk(A_STATUS, 8'h00, "no fifo event");
    pulse(1'b1, 1'b1);
    rd_chk(A_STATUS, 8'h02, "overflow");
    pulse(1'b0, 1'b1);
    rd_chk(A_STATUS, 8'h03, "underflow");
    sum_chk(1'b0);
    wr(A_UNMASK, 8'h02);
    rd_chk(A_UNMASK, 8'h02, "unmask rw");
    sum_chk(1'b1);
    wr(A_STATUS, 8'h02);
    sum_chk(1'b0);
    rd_chk(A_STATUS, 8'h01, "partial clear");
    wr(A_UNMASK, 8'h01);
    sum_chk(1'b1);
    wr(A_CLR, 8'h01);
    rd_chk(A_STATUS, 8'h00, "alias clear");
    sum_chk(1'b0);
    $display("test fifo done");

    // run-length limits and disable
    wr(A_UNMASK, 8'h04);
    rx_active <= 1'b1;
    send_bits(24, 1'b1);
    rd_chk(A_STATUS, 8'h00, "ones 24");
    send_bits(1, 1'b1);
    rd_chk(A_STATUS, 8'h04, "ones 25");
    sum_chk(1'b1);
    wr(A_STATUS, 8'h04);
    rx_active <= 1'b0;
    @(posedge clk);
    rx_active <= 1'b1;
    send_bits(26, 1'b0);
    rd_chk(A_STATUS, 8'h00, "zeros 26");
    send_bits(1, 1'b0);
    rd_chk(A_STATUS, 8'h04, "zeros 27");
    wr(A_STATUS, 8'h04);
    rx_active <= 1'b0;
    wr(A_RXCHK, 8'h01);
    rx_active <= 1'b1;
    send_bits(30, 1'b1);
    rd_chk(A_STATUS, 8'h00, "disabled");
    rx_active <= 1'b0;
    wr(A_RXCHK, 8'h00);
    $display("test run length done");

    // user pin edge select, every code both ways
    wr(A_UNMASK, 8'h08);
    for (int c = 0; c < 4; c++) begin
      wr(A_EDGE, 8'(c << 3));
      for (int e = 0; e < 2; e++) begin
        exp_flag = (c == 3) || (c == 1 && e == 0) || (c == 2 && e == 1);
        @(posedge clk);
        user_pin <= (e == 0);
        repeat (8) @(posedge clk);
        rd_chk(A_STATUS, {4'h0, exp_flag, 3'h0}, "user pin");
        sum_chk(exp_flag);
        wr(A_STATUS, 8'h08);
      end
    end
    $display("test user pin done");

    // pin function enables and byte enable
    wr(A_PIN, 8'h5A);
    rd_chk(A_PIN, 8'h5A, "pin rw");
    `CHK(pin_en, 8'h5A, "pin port")
    bus(1'b1, A_PIN, 8'h00, 4'h0);
    rd_chk(A_PIN, 8'h5A, "no byte enable");
    rd_chk(A_SUM, 8'h00, "summary reg");
    $display("test pin enable done");

    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
